//--- hdl/oct_params.svh
`ifndef OCT_PARAMS_SVH
`define OCT_PARAMS_SVH
// register byte offsets
`define OCT_CR_OFS 12'h000
`define OCT_RLD_OFS 12'h004
`define OCT_CNT_OFS 12'h008
`define OCT_IEN_OFS 12'h010
`define OCT_ISR_OFS 12'h014
`define OCT_FCLR_OFS 12'h01C
`define OCT_DBG_OFS 12'h020
`define OCT_FCAP_OFS 12'h080
`define OCT_TRIM_OFS 12'h084
`define OCT_LIM_OFS 12'h088
// operation_select codes
`define OCT_MODE_FAST 2'h0
`define OCT_MODE_SLOW 2'h1
`define OCT_MODE_TIMER 2'h3
// tick_source_select code of the pin
`define OCT_SRC_PIN 3'h4
// reset values and masks
`define OCT_RLD_RST 16'hFFFF
`define OCT_TRIM_RST 9'h100
`define OCT_TRIM_MAX 9'h1FF
`define OCT_IEN_MASK 6'h3B
// error limit is reload * 4 / 1000, i.e. 0.4 percent
`define OCT_TOL_NUM 18'h00004
`define OCT_TOL_DEN 18'h003E8
`endif

//--- hdl/oct_pkg.sv
`default_nettype none
package oct_pkg;
  // control register layout, bit 11 down to bit 0
  typedef struct packed {
    logic single_pass_select;
    logic [2:0] tick_source_select;
    logic [3:0] tick_divider;
    logic self_tune;
    logic [1:0] operation_select;
    logic run_enable;
  } oct_ctrl_s;
  // event flags, same layout as mask register
  typedef struct packed {
    logic count_fail_flag;
    logic tune_wrap_flag;
    logic underflow_flag;
    logic rsv;
    logic accuracy_met_flag;
    logic tune_done_flag;
  } oct_flags_s;
  typedef enum logic [1:0] {ST_IDLE, ST_TIMER, ST_CAL, ST_HOLD} oct_state_e;
endpackage
`default_nettype wire

//--- hdl/osc_cal_timer.sv
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "oct_params.svh"

module osc_cal_timer import oct_pkg::*; #(
  parameter int CNT_W = 16, // counter width
  parameter int TRIM_W = 9 // tune result width
) (
  input wire logic pclk, // bus clock, 40 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // unmapped address
  input wire logic fast_internal_osc, // oscillator level
  input wire logic slow_internal_osc, // oscillator level
  input wire logic fast_crystal, // crystal level
  input wire logic slow_crystal, // crystal level
  input wire logic external_tick_pin, // tick pin level
  input wire logic core_debug, // core in debug state
  output logic irq // interrupt request
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic pick(input logic [2:0] s, input logic [4:0] v);
    pick = (s <= `OCT_SRC_PIN) ? v[s] : 1'b0;
  endfunction

  // ----------------------------------------
  // bus and configuration registers
  // ----------------------------------------
  oct_ctrl_s ctrl_reg, ctrl_next;
  logic [CNT_W-1:0] rld_reg, rld_next, lim_reg, lim_next;
  logic [5:0] ien_reg, ien_next;
  logic dbg_halt_reg, dbg_halt_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  oct_flags_s flags_reg, flags_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next, fcap_reg, fcap_next;
  logic [TRIM_W-1:0] trim_reg, trim_next;
  logic up_reg, up_next, irq_reg, irq_next;
  logic [14:0] pre_reg, pre_next;
  logic [4:0] prev_reg;
  oct_state_e state_reg, state_next;

  logic acc, commit, wr, mapped;
  logic [17:0] prod;
  assign acc = psel & penable;
  // commit on the ready edge, the only edge the master takes the answer
  assign commit = acc & pready_reg;
  assign wr = commit & pwrite;
  assign mapped = hit(paddr, `OCT_CR_OFS) | hit(paddr, `OCT_RLD_OFS) | hit(paddr, `OCT_CNT_OFS)
    | hit(paddr, `OCT_IEN_OFS) | hit(paddr, `OCT_ISR_OFS) | hit(paddr, `OCT_FCLR_OFS)
    | hit(paddr, `OCT_DBG_OFS) | hit(paddr, `OCT_FCAP_OFS) | hit(paddr, `OCT_TRIM_OFS)
    | hit(paddr, `OCT_LIM_OFS);
  assign prod = 18'(rld_next) * `OCT_TOL_NUM;

  // register writes and read mux; ready comes one cycle into access
  always_comb begin
    ctrl_next = ctrl_reg;
    rld_next = rld_reg;
    ien_next = ien_reg;
    dbg_halt_next = dbg_halt_reg;
    pready_next = acc & ~pready_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    if (wr && hit(paddr, `OCT_CR_OFS)) begin
      ctrl_next = oct_ctrl_s'(pwdata[11:0]);
    end
    if (wr && hit(paddr, `OCT_RLD_OFS)) begin
      rld_next = pwdata[CNT_W-1:0];
    end
    if (wr && hit(paddr, `OCT_IEN_OFS)) begin
      ien_next = pwdata[5:0] & `OCT_IEN_MASK;
    end
    if (wr && hit(paddr, `OCT_DBG_OFS)) begin
      dbg_halt_next = pwdata[0];
    end
    // limit tracks the reload value, never written directly
    lim_next = CNT_W'(prod / `OCT_TOL_DEN);
    if (acc && !pready_reg) begin
      pslverr_next = ~mapped;
      prdata_next = 32'h0;
      if (hit(paddr, `OCT_CR_OFS)) prdata_next = {20'h0, ctrl_reg};
      if (hit(paddr, `OCT_RLD_OFS)) prdata_next = 32'(rld_reg);
      if (hit(paddr, `OCT_CNT_OFS)) prdata_next = 32'(cnt_reg);
      if (hit(paddr, `OCT_IEN_OFS)) prdata_next = {26'h0, ien_reg};
      if (hit(paddr, `OCT_ISR_OFS)) prdata_next = {26'h0, flags_reg};
      if (hit(paddr, `OCT_DBG_OFS)) prdata_next = {31'h0, dbg_halt_reg};
      if (hit(paddr, `OCT_FCAP_OFS)) prdata_next = 32'(fcap_reg);
      if (hit(paddr, `OCT_TRIM_OFS)) prdata_next = 32'(trim_reg);
      if (hit(paddr, `OCT_LIM_OFS)) prdata_next = 32'(lim_reg);
    end
  end

  // bus registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '0;
      rld_reg <= `OCT_RLD_RST;
      lim_reg <= '0;
      ien_reg <= 6'h00;
      dbg_halt_reg <= 1'b0;
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      rld_reg <= rld_next;
      lim_reg <= lim_next;
      ien_reg <= ien_next;
      dbg_halt_reg <= dbg_halt_next;
      pready_reg <= pready_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ----------------------------------------
  // tick edges, prescaler and counter core
  // ----------------------------------------
  logic [4:0] ticks, rise;
  logic halt, src_edge, base_edge, cnt_edge, pre_tick, slow_mode, inc;
  logic [14:0] mask;
  oct_flags_s set_v, clr_v;
  assign ticks = {external_tick_pin, slow_crystal, fast_crystal, slow_internal_osc, fast_internal_osc};
  assign rise = ticks & ~prev_reg;
  assign src_edge = pick(ctrl_reg.tick_source_select, rise);
  assign slow_mode = (ctrl_reg.operation_select == `OCT_MODE_SLOW);
  // slow mode divides the slow oscillator as reference, else the source
  assign base_edge = slow_mode ? rise[1] : src_edge;
  assign cnt_edge = slow_mode ? src_edge : rise[0];
  assign mask = 15'((16'h1 << ctrl_reg.tick_divider) - 16'h1);
  assign pre_tick = base_edge & ((pre_reg & mask) == mask);
  assign halt = core_debug & dbg_halt_reg;

  // state, counter, trim and flag updates
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    up_next = up_reg;
    trim_next = trim_reg;
    fcap_next = fcap_reg;
    pre_next = pre_reg;
    set_v = '0;
    inc = 1'b0;
    if (state_reg inside {ST_TIMER, ST_CAL} && !halt && base_edge) begin
      pre_next = pre_reg + 15'h1;
    end
    case (state_reg)
      ST_IDLE: begin
        pre_next = 15'h0;
        up_next = 1'b0;
        if (ctrl_reg.run_enable) begin
          if (ctrl_reg.operation_select == `OCT_MODE_TIMER) begin
            state_next = ST_TIMER;
            cnt_next = rld_reg;
          end else if (ctrl_reg.operation_select != 2'h2 && ctrl_reg.self_tune) begin
            state_next = ST_CAL;
            cnt_next = rld_reg;
          end
        end
      end
      ST_TIMER: begin
        if (!ctrl_reg.run_enable) begin
          state_next = ST_IDLE;
        end else if (!halt && pre_tick) begin
          if (cnt_reg == '0) begin
            set_v.underflow_flag = 1'b1;
            cnt_next = rld_reg;
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
      end
      ST_CAL: begin
        if (!ctrl_reg.run_enable) begin
          state_next = ST_IDLE;
        end else if (!halt && pre_tick) begin
          // count left at the gate edge is the error magnitude
          fcap_next = cnt_reg;
          cnt_next = rld_reg;
          up_next = 1'b0;
          if (cnt_reg <= lim_reg) begin
            set_v.accuracy_met_flag = 1'b1;
            set_v.tune_done_flag = 1'b1;
            if (ctrl_reg.single_pass_select) state_next = ST_HOLD;
          end else begin
            // too few counts: fast osc is slow, or slow osc is fast
            inc = ~up_reg ^ slow_mode;
            trim_next = inc ? trim_reg + 1'b1 : trim_reg - 1'b1;
            if ((inc && trim_reg == `OCT_TRIM_MAX) || (!inc && trim_reg == '0)) begin
              set_v.tune_wrap_flag = 1'b1;
            end
          end
        end else if (!halt && cnt_edge) begin
          if (!up_reg) begin
            up_next = (cnt_reg == '0);
            cnt_next = (cnt_reg == '0) ? CNT_W'(1) : cnt_reg - 1'b1;
          end else begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_next >= (rld_reg >> 1)) begin
              set_v.count_fail_flag = 1'b1;
              state_next = ST_HOLD;
            end
          end
        end
      end
      ST_HOLD: begin
        // stays stopped until software drops run enable
        if (!ctrl_reg.run_enable) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    clr_v = oct_flags_s'((wr && hit(paddr, `OCT_FCLR_OFS)) ? ~pwdata[5:0] : 6'h00);
    // a set in the clearing cycle wins
    flags_next = (flags_reg & ~clr_v) | set_v;
    flags_next.rsv = 1'b0;
    // next mask too, so the request never lags a mask write by a cycle
    irq_next = |(flags_next & ien_next);
  end

  // core registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      up_reg <= 1'b0;
      trim_reg <= `OCT_TRIM_RST;
      fcap_reg <= '0;
      pre_reg <= 15'h0;
      prev_reg <= 5'h00;
      flags_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      up_reg <= up_next;
      trim_reg <= trim_next;
      fcap_reg <= fcap_next;
      pre_reg <= pre_next;
      prev_reg <= ticks;
      flags_reg <= flags_next;
      irq_reg <= irq_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_irq_gate: assert property (irq == |(flags_reg & ien_reg))
    else $error("irq does not follow flags and mask");
  a_clear_zero: assert property (wr && hit(paddr, `OCT_FCLR_OFS) && !pwdata[3] && !set_v.underflow_flag
    |=> !flags_reg.underflow_flag)
    else $error("underflow flag not cleared by zero");
  a_clear_one: assert property (flags_reg.tune_done_flag && !(wr && hit(paddr, `OCT_FCLR_OFS) && !pwdata[0])
    |=> flags_reg.tune_done_flag)
    else $error("done flag lost without clear");
  a_debug_pause: assert property (halt && state_reg == ST_TIMER && ctrl_reg.run_enable
    |=> $stable(cnt_reg))
    else $error("counter moved in debug halt");
  a_underflow_reload: assert property (state_reg == ST_TIMER && ctrl_reg.run_enable && !halt
    && pre_tick && cnt_reg == '0 |=> cnt_reg == $past(rld_reg) && flags_reg.underflow_flag)
    else $error("underflow did not reload and flag");
  a_cal_needs_tune: assert property (state_reg == ST_IDLE && !ctrl_reg.self_tune |=> state_reg != ST_CAL)
    else $error("calibration started without self-tune");
  a_timer_mode: assert property (state_reg == ST_IDLE && ctrl_reg.run_enable
    && ctrl_reg.operation_select == `OCT_MODE_TIMER |=> state_reg == ST_TIMER)
    else $error("timer mode not entered");
  a_miss_stop: assert property (state_reg == ST_CAL && set_v.count_fail_flag
    |=> state_reg == ST_HOLD && flags_reg.count_fail_flag)
    else $error("count failure did not stop");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
endmodule
`default_nettype wire

//--- verification/oct_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------
// far side: oscillators and tick pin
// ----------
module oct_osc_model #(
  parameter int SLOW_HALF = 50, // slow osc half period, pclk
  parameter int XTAL_HALF = 1000 // slow crystal half period, pclk
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // reset, active low
  input wire logic pin_go, // start a pulse burst
  input wire logic [7:0] pin_n, // pulses in the burst
  output logic fast_osc, // toggles every pclk
  output logic slow_osc, // slow internal oscillator
  output logic fast_xtal, // toggles every two pclk
  output logic slow_xtal, // slow crystal, gate source
  output logic tick_pin // external pin, low between bursts
);
  int sc, xc;
  logic [7:0] left;
  logic [1:0] ph;
  // sources are synchronous levels; each level lasts one pclk or more
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {fast_osc, slow_osc, fast_xtal, slow_xtal, tick_pin} <= 5'h00;
      sc <= 0;
      xc <= 0;
      left <= 8'h00;
      ph <= 2'h0;
    end else begin
      fast_osc <= ~fast_osc;
      if (fast_osc) fast_xtal <= ~fast_xtal;
      sc <= (sc == SLOW_HALF - 1) ? 0 : sc + 1;
      if (sc == SLOW_HALF - 1) slow_osc <= ~slow_osc;
      xc <= (xc == XTAL_HALF - 1) ? 0 : xc + 1;
      if (xc == XTAL_HALF - 1) slow_xtal <= ~slow_xtal;
      // burst: two cycles high, two low per pulse
      tick_pin <= (left != 8'h00) && !ph[1];
      if (pin_go) begin
        left <= pin_n;
        ph <= 2'h0;
      end else if (left != 8'h00) begin
        ph <= ph + 2'h1;
        if (ph == 2'h3) left <= left - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "oct_params.svh"
// ----------
// bench top
// ----------
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, core_debug = 0, pin_go = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, irq, err, fo, so, fx, sx, tp;
  logic [7:0] pin_n = 8'h00;
  logic [15:0] c0;
  int error_cnt = 0, comparisons = 0, n;
  always #12.5 pclk = ~pclk;
  osc_cal_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_internal_osc(fo), .slow_internal_osc(so), .fast_crystal(fx), .slow_crystal(sx),
    .external_tick_pin(tp), .core_debug(core_debug), .irq(irq));
  oct_osc_model i_osc (.pclk(pclk), .presetn(presetn), .pin_go(pin_go), .pin_n(pin_n), .fast_osc(fo),
    .slow_osc(so), .fast_xtal(fx), .slow_xtal(sx), .tick_pin(tp));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // look mid-cycle, where ready and data have settled
    do begin
      @(negedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) chk("pready", 32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    // the transfer completes at this edge; release only after it
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask
  task automatic pulses(input int k);
    pin_n <= 8'(k);
    pin_go <= 1'b1;
    @(posedge pclk);
    pin_go <= 1'b0;
    repeat (4 * k + 8) @(posedge pclk);
  endtask
  task automatic wait_irq(input int lim);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < lim) begin
      @(posedge pclk);
      k++;
    end
  endtask
  // error limit expected for a reload value
  function automatic logic [31:0] limit_of(input logic [31:0] a);
    return a * 4 / 1000;
  endfunction
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, well beyond the expected run
  initial begin
    #1000000;
    error_cnt++;
    $display("watchdog expired");
    conclude;
  end
  initial begin
    void'($urandom(32'h9c88));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("irq reset", 32'(irq), 32'h0);
    rdc(`OCT_CR_OFS, 32'h0, "cr reset");
    rdc(`OCT_RLD_OFS, 32'hFFFF, "reload reset");
    rdc(`OCT_TRIM_OFS, 32'h100, "trim reset");
    rdc(`OCT_LIM_OFS, limit_of(32'hFFFF), "limit reset");
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    n = $urandom_range(0, 63);
    wr(`OCT_IEN_OFS, n);
    rdc(`OCT_IEN_OFS, n & 32'h3B, "mask bits");
    $display("test registers done");
    // timer on each oscillator and crystal source; src 3 needs a full crystal period
    for (int s = 0; s < 4; s++) begin
      wr(`OCT_CR_OFS, 32'h6 | (s << 8));
      wr(`OCT_CR_OFS, 32'h7 | (s << 8));
      repeat (2100) @(posedge pclk);
      apb(1'b0, `OCT_CNT_OFS, 32'h0);
      chk("cnt moves", 32'(rd[15:0] != 16'hFFFF), 32'h1);
    end
    n = $urandom_range(2, 6);
    wr(`OCT_CR_OFS, 32'h406);
    wr(`OCT_RLD_OFS, n - 1);
    wr(`OCT_IEN_OFS, 32'h08);
    wr(`OCT_CR_OFS, 32'h407);
    pulses(n - 1);
    chk("irq early", 32'(irq), 32'h0);
    pulses(1);
    chk("irq underflow", 32'(irq), 32'h1);
    rdc(`OCT_ISR_OFS, 32'h08, "underflow_flag");
    wr(`OCT_FCLR_OFS, 32'hFFFF_FFFF);
    rdc(`OCT_ISR_OFS, 32'h08, "isr held");
    wr(`OCT_FCLR_OFS, 32'hFFFF_FFF7);
    rdc(`OCT_ISR_OFS, 32'h0, "isr cleared");
    chk("irq cleared", 32'(irq), 32'h0);
    wr(`OCT_IEN_OFS, 32'h0);
    pulses(n);
    rdc(`OCT_ISR_OFS, 32'h08, "isr masked");
    chk("irq masked", 32'(irq), 32'h0);
    wr(`OCT_FCLR_OFS, 32'hFFFF_FFF7);
    wr(`OCT_DBG_OFS, 32'h1);
    core_debug <= 1'b1;
    apb(1'b0, `OCT_CNT_OFS, 32'h0);
    c0 = rd[15:0];
    pulses(1);
    rdc(`OCT_CNT_OFS, 32'(c0), "cnt halted");
    wr(`OCT_DBG_OFS, 32'h0);
    pulses(1);
    rdc(`OCT_CNT_OFS, 32'(c0) - 1, "cnt in debug");
    core_debug <= 1'b0;
    wr(`OCT_CR_OFS, 32'h406);
    apb(1'b0, `OCT_CNT_OFS, 32'h0);
    c0 = rd[15:0];
    wr(`OCT_CNT_OFS, $urandom);
    pulses(2);
    rdc(`OCT_CNT_OFS, 32'(c0), "cnt stopped");
    $display("test timer done");
    // no reference edges: source code 5 never ticks
    wr(`OCT_FCLR_OFS, 32'h0);
    wr(`OCT_IEN_OFS, 32'h20);
    wr(`OCT_RLD_OFS, 32'd20);
    rdc(`OCT_LIM_OFS, limit_of(32'd20), "limit small");
    wr(`OCT_CR_OFS, 32'h500);
    wr(`OCT_CR_OFS, 32'h501);
    repeat (300) @(posedge pclk);
    rdc(`OCT_ISR_OFS, 32'h0, "no self tune");
    wr(`OCT_CR_OFS, 32'h508);
    wr(`OCT_CR_OFS, 32'h509);
    wait_irq(500);
    chk("irq fail", 32'(irq), 32'h1);
    rdc(`OCT_ISR_OFS, 32'h20, "isr fail");
    $display("test count failure done");
    // slow mode, continuous, no counts: trim must step every gate
    wr(`OCT_CR_OFS, 32'h0);
    wr(`OCT_FCLR_OFS, 32'h0);
    wr(`OCT_IEN_OFS, 32'h0);
    wr(`OCT_CR_OFS, 32'h50A);
    wr(`OCT_CR_OFS, 32'h50B);
    repeat (600) @(posedge pclk);
    // software reads this nine-bit result to merge into the oscillator trim
    apb(1'b0, `OCT_TRIM_OFS, 32'h0);
    chk("trim stepped", 32'(rd !== 32'h100), 32'h1);
    // fast mode, single pass, reload matched to the crystal gate
    wr(`OCT_CR_OFS, 32'h0);
    wr(`OCT_FCLR_OFS, 32'h0);
    wr(`OCT_RLD_OFS, 32'd999);
    rdc(`OCT_LIM_OFS, limit_of(32'd999), "limit");
    wr(`OCT_IEN_OFS, 32'h03);
    wr(`OCT_CR_OFS, 32'hB08);
    wr(`OCT_CR_OFS, 32'hB09);
    wait_irq(8000);
    chk("irq tune", 32'(irq), 32'h1);
    rdc(`OCT_ISR_OFS, 32'h03, "isr tune");
    $display("test calibration done");
    conclude;
  end
endmodule
`default_nettype wire
